// *** lmac_defines.vh ***
// Constants for the LCD mode and access control block.
// Notes on behaviour
// - Step-up circuit runs while boost_on is 1, halts at 0 (reset).
// - Writing module_sleep 1 halts boost and operation, blanks display, keeps boost_on.
// - register_select low writes index; high steers access to indexed register.
// - All control registers except display data are write-only; reads return nothing.
// - graphic_mode_sel 0 selects character mode; only five low data bits drive segments.
// - graphic_mode_sel 1 selects graphic mode; all eight data bits drive segments.
// - Graphic mode X limit is 4, 6 or 7 at 1/32, 1/16, 1/8 duty.
// - duty_select 00 gives 1/32, 01 gives 1/16, 1x gives 1/8.
// - At 1/16 duty Y addresses 0x10 to 0x1F are invalid.
// - At 1/8 duty Y addresses 0x08 to 0x1F are invalid.
// - Reset clears every implemented bit of the second control register.
// - panel_drive_on 0 turns panel off with all outputs at ground.
// - Writing module_sleep 1 forces panel_drive_on to 0.
// - Writing module_sleep 1 forces opamp_run to 0.
// - opamp_run 0 halts op-amps with outputs high impedance; 1 runs them.
// - read_modify_write 0 advances address after every data read and write.
// - read_modify_write 1 advances address only after data writes.
// - At maximum valid value the stepped axis clears and the other increments.
// - address_step_axis 0 steps Y first; X advances on Y overflow.
// - address_step_axis 1 steps X first; Y advances on X overflow.
// - Blink only with blink_enable 1 and panel on, within blink range.
`ifndef LMAC_DEFINES_VH
`define LMAC_DEFINES_VH
`define LMAC_IDX_CTRL1 4'h0
`define LMAC_IDX_CTRL2 4'h1
`define LMAC_IDX_ADDR 4'h2
`define LMAC_IDX_DATA 4'h4
`define LMAC_IDX_BLINK 4'h6
`define LMAC_IDX_BFIRST 4'h8
`define LMAC_IDX_BLAST 4'h9
`define LMAC_C1_SLEEP 5
`define LMAC_C1_BOOST 4
`define LMAC_C1_GRAPH 2
`define LMAC_C1_DUTY_HI 1
`define LMAC_C1_DUTY_LO 0
`define LMAC_C2_PANEL 6
`define LMAC_C2_OPAMP 4
`define LMAC_C2_RMW 3
`define LMAC_C2_AXIS 1
`define LMAC_C2_BLINK 0
`define LMAC_RESET_BYTE 8'h00
`define LMAC_XMAX_32 3'h4
`define LMAC_XMAX_16 3'h6
`define LMAC_XMAX_8 3'h7
`define LMAC_YMAX_32 5'h1f
`define LMAC_YMAX_16 5'h0f
`define LMAC_YMAX_8 5'h07
`define LMAC_CHAR_MASK 8'h1f
`define LMAC_DUTY_32 2'h0
`define LMAC_DUTY_16 2'h1
`define LMAC_DUTY_8 2'h2
`endif

// *** lmac_addr_step.v ***
// Display memory X/Y address stepping with duty-dependent limits.
`timescale 1ns/1ps
`include "lmac_defines.vh"
module lmac_addr_step (
  input wire clk_sys,
  input wire reset_n,
  input wire load,
  input wire [7:0] load_value,
  input wire step,
  input wire axis_x_first,
  input wire [1:0] duty,
  input wire graphic,
  output reg [2:0] x_addr,
  output reg [4:0] y_addr
);
  reg [2:0] x_max;
  reg [4:0] y_max;
  reg [2:0] next_x;
  reg [4:0] next_y;

  // ==========================================
  // Valid area limits.
  always @* begin
    case (duty)
      `LMAC_DUTY_32: begin
        y_max = `LMAC_YMAX_32;
        // Only graphic mode narrows the X range; character mode keeps all eight columns.
        x_max = graphic ? `LMAC_XMAX_32 : `LMAC_XMAX_8;
      end
      `LMAC_DUTY_16: begin
        y_max = `LMAC_YMAX_16;
        x_max = graphic ? `LMAC_XMAX_16 : `LMAC_XMAX_8;
      end
      default: begin
        y_max = `LMAC_YMAX_8;
        x_max = `LMAC_XMAX_8;
      end
    endcase
  end

  // ==========================================
  // Stepping with carry into the other axis.
  always @* begin
    next_x = x_addr;
    next_y = y_addr;
    if (axis_x_first) begin
      if (x_addr >= x_max) begin
        next_x = 3'h0;
        next_y = (y_addr >= y_max) ? 5'h00 : y_addr + 5'h01;
      end else begin
        next_x = x_addr + 3'h1;
      end
    end else begin
      if (y_addr >= y_max) begin
        next_y = 5'h00;
        next_x = (x_addr >= x_max) ? 3'h0 : x_addr + 3'h1;
      end else begin
        next_y = y_addr + 5'h01;
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      x_addr <= 3'h0;
      y_addr <= 5'h00;
    end else if (load) begin
      x_addr <= load_value[7:5];
      y_addr <= load_value[4:0];
    end else if (step) begin
      x_addr <= next_x;
      y_addr <= next_y;
    end
  end
endmodule

// *** lmac_ctrl.v ***
// LCD mode and access control: index port, control registers, display memory, panel outputs.
`timescale 1ns/1ps
`include "lmac_defines.vh"
module lmac_ctrl #(
  parameter X_SIZE = 8,
  parameter Y_SIZE = 32
) (
  input wire clk_sys,
  input wire reset_n,
  input wire register_select,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  input wire [4:0] scan_line,
  input wire [2:0] scan_x,
  input wire blink_phase,
  output reg [7:0] seg_data,
  output wire panel_on,
  output wire boost_run,
  output wire opamp_enable,
  output wire module_standby,
  output wire graphic_mode,
  output wire [1:0] duty_mode,
  output wire [2:0] x_addr,
  output wire [4:0] y_addr
);
  reg [3:0] index_pointer;
  reg boost_on;
  reg module_sleep;
  reg graphic_mode_sel;
  reg duty_select_hi;
  reg duty_select_lo;
  reg panel_drive_on;
  reg opamp_run;
  reg read_modify_write;
  reg address_step_axis;
  reg blink_enable;
  reg [7:0] blink_columns;
  reg [4:0] blink_first_value;
  reg [4:0] blink_last_value;
  reg [7:0] panel_drive_on_mem [0:X_SIZE*Y_SIZE-1];
  reg [1:0] duty_code;
  reg [7:0] pix;
  reg in_blink;
  wire sel_data;
  wire data_wr;
  wire data_rd;
  wire addr_load;
  wire addr_step;
  wire y_valid;

  // ==========================================
  // Register access through index pointer.
  assign sel_data = register_select && (index_pointer == `LMAC_IDX_DATA);
  assign data_wr = wr_strobe && sel_data;
  assign data_rd = rd_strobe && sel_data;
  assign addr_load = wr_strobe && register_select && (index_pointer == `LMAC_IDX_ADDR);
  assign addr_step = data_wr || (data_rd && !read_modify_write);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      index_pointer <= 4'h0;
      boost_on <= 1'b0;
      module_sleep <= 1'b0;
      graphic_mode_sel <= 1'b0;
      duty_select_hi <= 1'b0;
      duty_select_lo <= 1'b0;
      panel_drive_on <= 1'b0;
      opamp_run <= 1'b0;
      read_modify_write <= 1'b0;
      address_step_axis <= 1'b0;
      blink_enable <= 1'b0;
      blink_columns <= `LMAC_RESET_BYTE;
      blink_first_value <= 5'h00;
      blink_last_value <= 5'h00;
    end else if (wr_strobe) begin
      if (!register_select) begin
        index_pointer <= wr_data[3:0];
      end else begin
        case (index_pointer)
          `LMAC_IDX_CTRL1: begin
            module_sleep <= wr_data[`LMAC_C1_SLEEP];
            boost_on <= wr_data[`LMAC_C1_BOOST];
            graphic_mode_sel <= wr_data[`LMAC_C1_GRAPH];
            duty_select_hi <= wr_data[`LMAC_C1_DUTY_HI];
            duty_select_lo <= wr_data[`LMAC_C1_DUTY_LO];
            if (wr_data[`LMAC_C1_SLEEP]) begin
              panel_drive_on <= 1'b0;
              opamp_run <= 1'b0;
            end
          end
          `LMAC_IDX_CTRL2: begin
            panel_drive_on <= wr_data[`LMAC_C2_PANEL];
            opamp_run <= wr_data[`LMAC_C2_OPAMP];
            read_modify_write <= wr_data[`LMAC_C2_RMW];
            address_step_axis <= wr_data[`LMAC_C2_AXIS];
            blink_enable <= wr_data[`LMAC_C2_BLINK];
          end
          `LMAC_IDX_BLINK: blink_columns <= wr_data;
          `LMAC_IDX_BFIRST: blink_first_value <= wr_data[4:0];
          `LMAC_IDX_BLAST: blink_last_value <= wr_data[4:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================
  // Duty decode and address stepping.
  always @* begin
    if (duty_select_hi) begin
      duty_code = `LMAC_DUTY_8;
    end else if (duty_select_lo) begin
      duty_code = `LMAC_DUTY_16;
    end else begin
      duty_code = `LMAC_DUTY_32;
    end
  end

  lmac_addr_step u_step (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(addr_load),
    .load_value(wr_data),
    .step(addr_step),
    .axis_x_first(address_step_axis),
    .duty(duty_code),
    .graphic(graphic_mode_sel),
    .x_addr(x_addr),
    .y_addr(y_addr)
  );

  // ==========================================
  // Display memory, reads only from data register.
  always @(posedge clk_sys) begin
    if (data_wr) begin
      panel_drive_on_mem[{y_addr, x_addr}] <= wr_data;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else if (data_rd) begin
      rd_data <= panel_drive_on_mem[{y_addr, x_addr}];
    end else if (rd_strobe) begin
      rd_data <= 8'h00;
    end
  end

  // ==========================================
  // Segment data toward the panel.
  assign y_valid = (duty_code == `LMAC_DUTY_32) ||
                   ((duty_code == `LMAC_DUTY_16) && (scan_line <= `LMAC_YMAX_16)) ||
                   (scan_line <= `LMAC_YMAX_8);

  always @* begin
    pix = panel_drive_on_mem[{scan_line, scan_x}];
    if (!graphic_mode_sel) begin
      pix = pix & `LMAC_CHAR_MASK;
    end
    // Otherwise all eight bits pass.
    in_blink = (scan_line >= blink_first_value) && (scan_line <= blink_last_value);
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seg_data <= 8'h00;
    end else if (!panel_drive_on || module_sleep || !y_valid) begin
      seg_data <= 8'h00;
    end else if (blink_enable && in_blink && blink_phase) begin
      seg_data <= pix & ~blink_columns;
    end else begin
      seg_data <= pix;
    end
  end

  assign panel_on = panel_drive_on && !module_sleep;
  assign boost_run = boost_on && !module_sleep;
  assign opamp_enable = opamp_run;
  assign module_standby = module_sleep;
  assign graphic_mode = graphic_mode_sel;
  assign duty_mode = duty_code;
endmodule

// *** lmac_ctrl_sva.sv ***
// Checker for the LCD mode and access control ports.
`timescale 1ns/1ps
module lmac_ctrl_sva (
  input wire clk_sys,
  input wire reset_n,
  input wire register_select,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire [4:0] scan_line,
  input wire [7:0] seg_data,
  input wire panel_on,
  input wire boost_run,
  input wire opamp_enable,
  input wire module_standby,
  input wire graphic_mode,
  input wire [1:0] duty_mode,
  input wire [2:0] x_addr,
  input wire [4:0] y_addr
);
  // The index and the read-modify-write bit are not visible at the ports, so they are shadowed here.
  reg [3:0] idx_q;
  reg rmw_q;
  wire w0 = wr_strobe && register_select && idx_q == 4'h0;
  wire w1 = wr_strobe && register_select && idx_q == 4'h1;
  wire dacc = register_select && idx_q == 4'h4 && !module_standby;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idx_q <= 4'h0;
      rmw_q <= 1'b0;
    end else begin
      if (wr_strobe && !register_select) idx_q <= wr_data[3:0];
      if (w1) rmw_q <= wr_data[3];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_panel_wr;
    w1 && !module_standby |=> panel_on == $past(wr_data[6]) && opamp_enable == $past(wr_data[4]);
  endproperty
  a_panel_wr: assert property (p_panel_wr) else $error("panel or opamp not set by write");
  property p_mode_wr;
    w0 && !wr_data[5] |=> duty_mode == ($past(wr_data[1]) ? 2'h2 : {1'b0, $past(wr_data[0])})
      && graphic_mode == $past(wr_data[2]) && boost_run == $past(wr_data[4]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode, duty or boost wrong");
  property p_sleep;
    w0 && wr_data[5] |=> module_standby && !panel_on && !opamp_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not clear panel and opamp");
  property p_standby;
    module_standby |-> !boost_run && !panel_on;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left boost or panel on");
  property p_blank;
    !panel_on [*2] |=> seg_data == 8'h00;
  endproperty
  a_blank: assert property (p_blank) else $error("segments driven with panel off");
  property p_char;
    !graphic_mode [*2] |=> seg_data[7:5] == 3'h0;
  endproperty
  a_char: assert property (p_char) else $error("high segment bits in character mode");
  property p_bad_y;
    $stable(duty_mode) && (duty_mode == 2'h1 && scan_line[4] || duty_mode == 2'h2 && scan_line[4:3] != 2'h0)
      |=> seg_data == 8'h00;
  endproperty
  a_bad_y: assert property (p_bad_y) else $error("invalid line shown");
  property p_rd_zero;
    rd_strobe && !(register_select && idx_q == 4'h4) |=> rd_data == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("write-only register read back");
  property p_rmw_hold;
    rd_strobe && dacc && rmw_q |=> $stable(x_addr) && $stable(y_addr);
  endproperty
  a_rmw_hold: assert property (p_rmw_hold) else $error("address moved on rmw read");
  property p_step;
    (wr_strobe || rd_strobe && !rmw_q) && dacc |=> {x_addr, y_addr} != $past({x_addr, y_addr});
  endproperty
  a_step: assert property (p_step) else $error("address did not advance");
endmodule
bind lmac_ctrl lmac_ctrl_sva u_lmac_ctrl_sva (.clk_sys(clk_sys), .reset_n(reset_n),
  .register_select(register_select), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data),
  .rd_data(rd_data), .scan_line(scan_line), .seg_data(seg_data), .panel_on(panel_on), .boost_run(boost_run),
  .opamp_enable(opamp_enable), .module_standby(module_standby), .graphic_mode(graphic_mode),
  .duty_mode(duty_mode), .x_addr(x_addr), .y_addr(y_addr));

// *** lmac_panel_model.sv ***
// Panel model that sweeps the scan position and the blink phase.
`timescale 1ns/1ps
module lmac_panel_model (
  input wire clk_sys,
  input wire reset_n,
  output reg [4:0] scan_line,
  output reg [2:0] scan_x,
  output reg blink_phase
);
  // One column per cycle, a line every eight columns, blink phase flips after a full frame.
  always @(negedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {blink_phase, scan_line, scan_x} <= 9'h000;
    end else begin
      {blink_phase, scan_line, scan_x} <= {blink_phase, scan_line, scan_x} + 9'h001;
    end
  end
endmodule

// *** lmac_ctrl_test.sv ***
// Self-checking bench for the LCD mode and access control block.
`timescale 1ns/1ps
module lmac_ctrl_test;
  reg clk_sys, reset_n, register_select, wr_strobe, rd_strobe;
  reg [7:0] wr_data, d;
  wire [7:0] rd_data, seg_data;
  wire [4:0] scan_line, y_addr;
  wire [2:0] scan_x, x_addr;
  wire [1:0] duty_mode;
  wire blink_phase, panel_on, boost_run, opamp_enable, module_standby, graphic_mode;
  integer failures, cmp_count, i, k;
  lmac_ctrl u_lmac_ctrl (.clk_sys(clk_sys), .reset_n(reset_n), .register_select(register_select),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data), .rd_data(rd_data), .scan_line(scan_line),
    .scan_x(scan_x), .blink_phase(blink_phase), .seg_data(seg_data), .panel_on(panel_on), .boost_run(boost_run),
    .opamp_enable(opamp_enable), .module_standby(module_standby), .graphic_mode(graphic_mode),
    .duty_mode(duty_mode), .x_addr(x_addr), .y_addr(y_addr));
  lmac_panel_model u_lmac_panel_model (.clk_sys(clk_sys), .reset_n(reset_n), .scan_line(scan_line),
    .scan_x(scan_x), .blink_phase(blink_phase));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function [1:0] exp_duty(input [1:0] s);
    exp_duty = s[1] ? 2'h2 : s;
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input rs, input rd, input [7:0] v);
    begin
      @(negedge clk_sys);
      register_select = rs;
      wr_data = v;
      wr_strobe = !rd;
      rd_strobe = rd;
      @(negedge clk_sys);
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
    end
  endtask
  task wreg(input [3:0] ix, input [7:0] v);
    begin
      acc(1'b0, 1'b0, {4'h0, ix});
      acc(1'b1, 1'b0, v);
    end
  endtask
  // Waits for the panel scan to reach the given X/Y position, then compares the segment byte shown there.
  task see(input [7:0] pos, input [7:0] exp);
    begin
      k = 0;
      @(posedge clk_sys);
      while (k < 600 && {scan_x, scan_line} !== pos) begin
        @(posedge clk_sys);
        k = k + 1;
      end
      @(negedge clk_sys);
      if (k == 600) begin
        failures = failures + 1;
        $display("MISMATCH %0t scan position never reached", $time);
      end
      check(seg_data, exp);
    end
  endtask
  // Sets mode and address, writes one data byte, checks the stepped address, then checks the byte once the scan reaches that position.
  task step(input [7:0] c1, input [7:0] c2, input [7:0] a, input [7:0] e);
    begin
      wreg(4'h0, c1);
      wreg(4'h1, c2);
      wreg(4'h2, a);
      d = 8'($urandom);
      wreg(4'h4, d);
      check({x_addr, y_addr}, e);
      see(a, c1[2] ? d : (d & 8'h1f));
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    #1_000_000;
    failures = failures + 1;
    end_sim;
  end
  initial begin
    failures = 0;
    cmp_count = 0;
    {register_select, wr_strobe, rd_strobe, wr_data} = 11'h000;
    reset_n = 1'b0;
    d = 8'($urandom(76361));
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    check({x_addr, y_addr}, 8'h00);
    check({panel_on, opamp_enable, boost_run, module_standby, graphic_mode, duty_mode}, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      d = (8'($urandom) & 8'h14) | {6'h00, i[1:0]};
      wreg(4'h0, d);
      check({6'h00, duty_mode}, {6'h00, exp_duty(d[1:0])});
      check({4'h0, boost_run, graphic_mode, duty_mode}, {4'h0, d[4], d[2], exp_duty(d[1:0])});
    end
    wreg(4'h1, 8'h50);
    check({panel_on, opamp_enable}, 8'h03);
    wreg(4'h0, 8'h30);
    check({module_standby, boost_run, panel_on, opamp_enable}, 8'h08);
    repeat (2) @(negedge clk_sys);
    check(seg_data, 8'h00);
    wreg(4'h0, 8'h10);
    check({module_standby, boost_run, panel_on}, 8'h02);
    $display("mode test done");
    step(8'h10, 8'h40, 8'h3f, 8'h40);
    step(8'h10, 8'h42, 8'h80, 8'ha0);
    step(8'h15, 8'h42, 8'hc0, 8'h01);
    step(8'h15, 8'h40, 8'h2f, 8'h40);
    step(8'h16, 8'h42, 8'he3, 8'h04);
    step(8'h16, 8'h41, 8'h27, 8'h40);
    step(8'h14, 8'h42, 8'h80, 8'h01);
    d = 8'($urandom);
    wreg(4'h1, 8'h4a);
    wreg(4'h2, 8'h83);
    wreg(4'h4, d);
    wreg(4'h2, 8'h83);
    acc(1'b0, 1'b0, 8'h04);
    acc(1'b1, 1'b1, 8'h00);
    check(rd_data, d);
    check({x_addr, y_addr}, 8'h83);
    wreg(4'h1, 8'h42);
    wreg(4'h2, 8'h83);
    acc(1'b0, 1'b0, 8'h04);
    acc(1'b1, 1'b1, 8'h00);
    check({x_addr, y_addr}, 8'h04);
    acc(1'b0, 1'b0, 8'h00);
    acc(1'b1, 1'b1, 8'h00);
    check(rd_data, 8'h00);
    $display("address test done");
    end_sim;
  end
endmodule
